// ---- rtl/csda_core.sv ----
// compare-skip (equal, greater, less) and decimal adjust execution
// assumes one clock per quarter phase and a core that fetches in Q1,
// serves the file byte in Q2 and flushes while o_flush is high
`include "csda_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module csda_core
(
	input  wire logic                        i_clk,
	input  wire logic                        i_reset,
	input  wire csda_pkg::csda_apb_req_type  i_apb,
	output var  csda_pkg::csda_apb_rsp_type  o_apb,
	input  wire logic [15:0]                 i_instr,
	input  wire logic                        i_next_two_word,
	input  wire logic [7:0]                  i_file_data,
	output var  csda_pkg::csda_file_addr_type o_file_addr,
	output logic                             o_file_rd,
	output logic                             o_flush,
	output logic [3:0]                       o_phase
);

	csda_pkg::csda_state_type s_reg;
	csda_pkg::csda_state_type s_next;
	logic [8:0]               diff;
	logic                     is_equal;
	logic                     is_less;
	logic                     is_greater;
	logic [4:0]               low_sum;
	logic [4:0]               high_sum;
	logic                     low_fix;
	logic                     high_fix;

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == `CSDA_ADDR_WORK) || (addr == `CSDA_ADDR_FLAGS) ||
			(addr == `CSDA_ADDR_BANK) || (addr == `CSDA_ADDR_STATE);
	endfunction

	function automatic csda_pkg::csda_cmd_type decode(input logic [15:0] op);
		if (op[15:9] == `CSDA_OP_CMP_EQUAL)
			decode = csda_pkg::CMD_EQUAL;
		else if (op[15:9] == `CSDA_OP_CMP_GREATER)
			decode = csda_pkg::CMD_GREATER;
		else if (op[15:9] == `CSDA_OP_CMP_LESS)
			decode = csda_pkg::CMD_LESS;
		else if (op == `CSDA_OP_DECIMAL)
			decode = csda_pkg::CMD_DECIMAL;
		else
			decode = csda_pkg::CMD_NONE;
	endfunction

	// unsigned byte minus working register, internal only
	always_comb
	begin
		diff       = {1'b0, s_reg.file_byte} - {1'b0, s_reg.working_register};
		is_equal   = (diff[7:0] == 8'h00);
		is_less    = diff[8];
		is_greater = !diff[8] && !is_equal;
	end

	// nibble corrections, each nibble judged on its own
	always_comb
	begin
		low_fix  = (s_reg.working_register[3:0] > `CSDA_BCD_LIMIT) ||
			s_reg.digit_carry_flag;
		high_fix = (s_reg.working_register[7:4] > `CSDA_BCD_LIMIT) ||
			s_reg.carry;
		low_sum  = {1'b0, s_reg.working_register[3:0]} +
			(low_fix ? {1'b0, `CSDA_BCD_FIX} : 5'h00);
		high_sum = {1'b0, s_reg.working_register[7:4]} +
			(high_fix ? {1'b0, `CSDA_BCD_FIX} : 5'h00);
	end

	always_comb
	begin
		s_next        = s_reg;
		s_next.slverr = 1'b0;
		case (s_reg.phase)
			csda_pkg::PH_Q1:
			begin
				s_next.phase    = csda_pkg::PH_Q2;
				s_next.skip_hit = 1'b0;
				if (s_reg.flush_cnt != 2'h0)
					s_next.cmd = csda_pkg::CMD_NONE;
				else
					s_next.cmd = decode(i_instr);
				s_next.file_addr.offset = i_instr[7:0];
				s_next.file_addr.access_bank = !i_instr[8];
				s_next.file_addr.bank = i_instr[8] ?
					s_reg.bank_select_register : `CSDA_RST_BANK;
			end
			csda_pkg::PH_Q2:
			begin
				s_next.phase = csda_pkg::PH_Q3;
				if (s_reg.cmd != csda_pkg::CMD_NONE &&
					s_reg.cmd != csda_pkg::CMD_DECIMAL)
					s_next.file_byte = i_file_data;
			end
			csda_pkg::PH_Q3:
			begin
				s_next.phase = csda_pkg::PH_Q4;
				case (s_reg.cmd)
					csda_pkg::CMD_EQUAL:
						s_next.skip_hit = is_equal;
					csda_pkg::CMD_GREATER:
						s_next.skip_hit = is_greater;
					csda_pkg::CMD_LESS:
						s_next.skip_hit = is_less;
					default:
						s_next.skip_hit = 1'b0;
				endcase
				s_next.adjusted       = {high_sum[3:0], low_sum[3:0]};
				s_next.adjusted_carry = high_sum[4];
			end
			csda_pkg::PH_Q4:
			begin
				s_next.phase = csda_pkg::PH_Q1;
				if (s_reg.skip_hit)
					s_next.flush_cnt = i_next_two_word ?
						`CSDA_FLUSH_TWO : `CSDA_FLUSH_ONE;
				else if (s_reg.flush_cnt != 2'h0)
					s_next.flush_cnt = s_reg.flush_cnt - 2'h1;
				if (s_reg.cmd != csda_pkg::CMD_NONE &&
					s_reg.cmd != csda_pkg::CMD_DECIMAL)
					s_next.skip_last = s_reg.skip_hit;
			end
			default:
				s_next.phase = csda_pkg::PH_Q1;
		endcase

		// register bus: read data and error captured in setup
		if (i_apb.psel && !i_apb.penable)
		begin
			s_next.slverr = !mapped(i_apb.paddr);
			case (i_apb.paddr)
				`CSDA_ADDR_WORK:
					s_next.rdata = {24'h000000, s_reg.working_register};
				`CSDA_ADDR_FLAGS:
					s_next.rdata = {30'h00000000, s_reg.digit_carry_flag,
						s_reg.carry};
				`CSDA_ADDR_BANK:
					s_next.rdata = {28'h0000000, s_reg.bank_select_register};
				`CSDA_ADDR_STATE:
					s_next.rdata = {26'h0000000, s_reg.phase,
						(s_reg.flush_cnt != 2'h0), s_reg.skip_last};
				default:
					s_next.rdata = 32'h00000000;
			endcase
		end
		else if (i_apb.psel && i_apb.penable)
			s_next.slverr = s_reg.slverr;

		if (i_apb.psel && i_apb.penable && i_apb.pwrite)
		begin
			case (i_apb.paddr)
				`CSDA_ADDR_WORK:
					s_next.working_register = i_apb.pwdata[7:0];
				`CSDA_ADDR_FLAGS:
				begin
					s_next.carry = i_apb.pwdata[`CSDA_FLAG_CARRY];
					s_next.digit_carry_flag = i_apb.pwdata[`CSDA_FLAG_DIGIT];
				end
				`CSDA_ADDR_BANK:
					s_next.bank_select_register = i_apb.pwdata[3:0];
				default:
					s_next.rdata = s_next.rdata;
			endcase
		end

		// decimal adjust write back in Q4 wins over a bus write
		if (s_reg.phase == csda_pkg::PH_Q4 &&
			s_reg.cmd == csda_pkg::CMD_DECIMAL)
		begin
			s_next.working_register = s_reg.adjusted;
			s_next.carry = s_reg.carry | s_reg.adjusted_carry;
			s_next.digit_carry_flag = s_reg.digit_carry_flag;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			s_reg                      <= '0;
			s_reg.phase                <= csda_pkg::PH_Q1;
			s_reg.cmd                  <= csda_pkg::CMD_NONE;
			s_reg.working_register     <= `CSDA_RST_WORK;
			s_reg.bank_select_register <= `CSDA_RST_BANK;
		end
		else
			s_reg <= s_next;
	end

	// compares never touch the flags: only Q4 of decimal adjust and a bus write to the flags register do
	always_comb
	begin
		o_apb.pready  = i_apb.psel && i_apb.penable;
		o_apb.pslverr = i_apb.psel && i_apb.penable && s_reg.slverr;
		o_apb.prdata  = s_reg.rdata;
		o_file_addr   = s_reg.file_addr;
		o_file_rd     = (s_reg.phase == csda_pkg::PH_Q2) &&
			(s_reg.cmd != csda_pkg::CMD_NONE) &&
			(s_reg.cmd != csda_pkg::CMD_DECIMAL);
		o_flush       = (s_reg.flush_cnt != 2'h0);
		o_phase       = s_reg.phase;
	end

endmodule // csda_core
`default_nettype wire

// ---- rtl/csda_defines.svh ----
// constants of the compare-skip and decimal adjust datapath
// assumes a free running four phase instruction cycle, one phase per clock
`ifndef CSDA_DEFINES_SVH
`define CSDA_DEFINES_SVH

`define CSDA_ADDR_WORK      8'h00
`define CSDA_ADDR_FLAGS     8'h04
`define CSDA_ADDR_BANK      8'h08
`define CSDA_ADDR_STATE     8'h0C

`define CSDA_FLAG_CARRY     0
`define CSDA_FLAG_DIGIT     1
`define CSDA_STATE_SKIP     0
`define CSDA_STATE_FLUSH    1
`define CSDA_STATE_PHASE    2

`define CSDA_RST_WORK       8'h00
`define CSDA_RST_BANK       4'h0

`define CSDA_OP_CMP_LESS    7'h30
`define CSDA_OP_CMP_EQUAL   7'h31
`define CSDA_OP_CMP_GREATER 7'h32
`define CSDA_OP_DECIMAL     16'h0007

`define CSDA_BCD_LIMIT      4'h9
`define CSDA_BCD_FIX        4'h6
`define CSDA_FLUSH_ONE      2'h1
`define CSDA_FLUSH_TWO      2'h2

`endif

// ---- rtl/csda_pkg.sv ----
// types of the compare-skip and decimal adjust datapath
// phase and command encodings are literals here, not taken from csda_defines.svh
`default_nettype none
package csda_pkg;

	typedef enum logic [3:0]
	{
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} csda_phase_type;

	typedef enum logic [4:0]
	{
		CMD_NONE    = 5'b00001,
		CMD_EQUAL   = 5'b00010,
		CMD_GREATER = 5'b00100,
		CMD_LESS    = 5'b01000,
		CMD_DECIMAL = 5'b10000
	} csda_cmd_type;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} csda_apb_req_type;

	typedef struct packed
	{
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} csda_apb_rsp_type;

	typedef struct packed
	{
		logic       access_bank;
		logic [3:0] bank;
		logic [7:0] offset;
	} csda_file_addr_type;

	typedef struct packed
	{
		csda_phase_type     phase;
		csda_cmd_type       cmd;
		csda_file_addr_type file_addr;
		logic [7:0]         file_byte;
		logic [7:0]         working_register;
		logic               carry;
		logic               digit_carry_flag;
		logic [3:0]         bank_select_register;
		logic               skip_hit;
		logic               skip_last;
		logic [1:0]         flush_cnt;
		logic [7:0]         adjusted;
		logic               adjusted_carry;
		logic [31:0]        rdata;
		logic               slverr;
	} csda_state_type;

endpackage
`default_nettype wire

// ---- sim/compare_skip_decimal_adjust_bench.sv ----
// self-checking bench for csda_core
// assumes csda_pkg and csda_defines.svh; drives APB and instruction link
`include "csda_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module compare_skip_decimal_adjust_bench;
	logic                         i_clk = 1'b0;
	logic                         i_reset = 1'b1;
	csda_pkg::csda_apb_req_type   i_apb = '0;
	csda_pkg::csda_apb_rsp_type   o_apb;
	logic [15:0]                  i_instr = 16'h0000;
	logic                         i_next_two_word = 1'b0;
	logic [7:0]                   i_file_data = 8'h00;
	csda_pkg::csda_file_addr_type o_file_addr;
	logic                         o_file_rd;
	logic                         o_flush;
	logic [3:0]                   o_phase;
	logic [15:0]                  follow = 16'h0000;
	int                           errors = 0;
	int                           n_compared = 0;
	csda_core dut (.i_clk, .i_reset, .i_apb, .o_apb, .i_instr,
		.i_next_two_word, .i_file_data, .o_file_addr, .o_file_rd,
		.o_flush, .o_phase);
	always #2 i_clk = ~i_clk;
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		i_apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		i_apb.penable <= 1'b1;
		do
			@(posedge i_clk);
		while (o_apb.pready !== 1'b1);
		q = o_apb.prdata;
		e = o_apb.pslverr;
		i_apb.psel <= 1'b0;
		i_apb.penable <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic run(input logic [15:0] ins, input logic [7:0] fb,
		input logic two, output int nf, output logic [12:0] fa);
		nf = 0;
		fa = '0;
		do
			@(posedge i_clk);
		while (o_phase !== 4'h8);
		i_instr <= ins;
		i_file_data <= fb;
		i_next_two_word <= two;
		for (int k = 0; k < 16; k++)
		begin
			@(posedge i_clk);
			i_instr <= (k == 3 || k == 7) ? follow : 16'h0000;
			nf += int'(o_flush !== 1'b0);
			if (o_file_rd === 1'b1)
				fa = o_file_addr;
		end
	endtask
	task automatic t_compare();
		logic [31:0] q;
		logic        e;
		int          nf;
		logic [12:0] fa;
		logic [7:0]  f;
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk("unmapped", {q[30:0], e}, 32'h1);
		apb(1'b1, `CSDA_ADDR_WORK, 32'h80, q, e);
		apb(1'b1, `CSDA_ADDR_FLAGS, 32'h3, q, e);
		apb(1'b1, `CSDA_ADDR_BANK, 32'h5, q, e);
		for (int c = 0; c < 3; c++)
			for (int v = 0; v < 3; v++)
			begin
				f = 8'hA0 + 8'(c * 3 + v);
				run({`CSDA_OP_CMP_LESS + 7'(c), c[0], f}, 8'h7F + 8'(v),
					1'b0, nf, fa);
				chk("flush", nf, (c == v) ? 4 : 0);
				chk("addr", fa, c[0] ? {1'b0, 4'h5, f} : {1'b1, 4'h0, f});
				apb(1'b0, `CSDA_ADDR_STATE, 32'h0, q, e);
				chk("state", q, (c == v) ? 32'h5 : 32'h4);
			end
		follow = `CSDA_OP_DECIMAL;
		run({`CSDA_OP_CMP_GREATER, 1'b0, 8'h10}, 8'hFF, 1'b1, nf, fa);
		follow = 16'h0000;
		chk("flush2", nf, 8);
		apb(1'b0, `CSDA_ADDR_FLAGS, 32'h0, q, e);
		chk("flags", q, 32'h3);
		apb(1'b0, `CSDA_ADDR_WORK, 32'h0, q, e);
		chk("work", q, 32'h80);
		$display("compare test done");
	endtask
	task automatic t_adjust();
		logic [31:0] q;
		logic        e;
		int          nf;
		logic [12:0] fa;
		logic [23:0] tv [5] = '{24'hA50501, 24'h0F0500, 24'h121822,
			24'h127211, 24'h999900};
		foreach (tv[i])
		begin
			apb(1'b1, `CSDA_ADDR_WORK, {24'h0, tv[i][23:16]}, q, e);
			apb(1'b1, `CSDA_ADDR_FLAGS, {28'h0, tv[i][7:4]}, q, e);
			run(`CSDA_OP_DECIMAL, 8'h00, 1'b0, nf, fa);
			chk("adj_flush", nf, 0);
			apb(1'b0, `CSDA_ADDR_WORK, 32'h0, q, e);
			chk("adj_work", q, {24'h0, tv[i][15:8]});
			apb(1'b0, `CSDA_ADDR_FLAGS, 32'h0, q, e);
			chk("adj_flags", q, {28'h0, tv[i][3:0]});
		end
		$display("adjust test done");
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		t_compare();
		t_adjust();
		conclude();
	end
	initial
	begin
		repeat (5000) @(posedge i_clk);
		errors++;
		conclude();
	end
endmodule // compare_skip_decimal_adjust_bench
`default_nettype wire

// ---- sim/csda_core_assertions.sv ----
// checker for the compare-skip and decimal adjust datapath
// assumes csda_pkg is compiled first; bound to csda_core below
`timescale 1ns/10ps
`default_nettype none
module csda_core_assertions
(
	input wire logic                         i_clk,
	input wire logic                         i_reset,
	input wire csda_pkg::csda_apb_req_type   i_apb,
	input wire csda_pkg::csda_apb_rsp_type   o_apb,
	input wire logic [15:0]                  i_instr,
	input wire logic                         i_next_two_word,
	input wire logic [7:0]                   i_file_data,
	input wire csda_pkg::csda_file_addr_type o_file_addr,
	input wire logic                         o_file_rd,
	input wire logic                         o_flush,
	input wire logic [3:0]                   o_phase
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	sequence s_cmp;
		o_phase == 4'h1 && !o_flush
			&& i_instr[15:9] inside {7'h30, 7'h31, 7'h32};
	endsequence
	sequence s_adj;
		o_phase == 4'h1 && !o_flush && i_instr == 16'h0007;
	endsequence
	AST_PHASE: assert property (o_phase == 4'h8 |=> o_phase == 4'h1)
		else $error("phase does not wrap to Q1");
	AST_BANK: assert property (s_cmp |=> o_file_rd
		&& o_file_addr.offset == $past(i_instr[7:0])
		&& o_file_addr.access_bank != $past(i_instr[8])
		&& ($past(i_instr[8]) || o_file_addr.bank == 4'h0))
		else $error("file address wrong");
	AST_RD: assert property (o_file_rd |-> o_phase == 4'h2 && !o_flush)
		else $error("file read outside Q2");
	AST_ADJ_NOSKIP: assert property (s_adj |=> !o_flush [*7])
		else $error("adjust caused a flush");
	AST_FLUSH_AT_Q1: assert property ($rose(o_flush)
		|-> o_phase == 4'h1 && $past(o_phase) == 4'h8)
		else $error("flush not started after Q4");
	AST_FLUSH_LEN: assert property ($rose(o_flush) |-> o_flush [*4])
		else $error("flush shorter than a cycle");
	AST_FLUSH_MAX: assert property (o_flush [*8] |=> !o_flush)
		else $error("flush longer than two cycles");
	AST_SKIP_SRC: assert property ($rose(o_flush)
		|-> $past(i_instr[15:11], 4) == 5'b01100)
		else $error("flush without a compare");
endmodule // csda_core_assertions
bind csda_core csda_core_assertions u_chk (.i_clk, .i_reset, .i_apb,
	.o_apb, .i_instr, .i_next_two_word, .i_file_data, .o_file_addr,
	.o_file_rd, .o_flush, .o_phase);
`default_nettype wire
